/* logic/adc_conv_ctrl.sv */
// Converter control: start and done, result layout, done flag, wake and vectoring
//
// Behaviour
// R1: Done flag sets after every conversion
// R2: Only software clears the done flag
// R3: Interrupt request needs done flag and enable; IRQ_O also rises on refused flag and its mask bit
// R4: Converter interrupt wakes device from sleep
// R5: After wake run next instruction first
// R6: Global enable clear: wake, continue in-line
// R7: All three enables set: vector to handler
// R8: Converts asleep only with RC clock
// R9: Result is left or right justified
// R10: Justify select picks stored result layout
// R11: Go flag starts conversion while converter on
// R12: Device clears go flag on completion
// R13: Software configures and waits before go
// R14: Fixed bit placement for both layouts
// R15: Result, flag, go clear in one cycle
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_conv_ctrl #(
   parameter int RESULT_W = 10
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   // Register port
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [7:0]  RDATA_O,
   // Core sleep and interrupt
   input  wire logic        SLEEP_REQ_I,
   output logic             ASLEEP_O,
   output logic             WAKE_O,
   output logic             EXEC_NEXT_O,
   output logic             VECTOR_O,
   output logic             IRQ_O,
   // Sample and convert circuit
   output logic             CONV_START_O,
   output logic             CONV_RUN_O,
   output logic      [2:0]  CONV_CHANNEL_O,
   output logic      [2:0]  CONV_CLK_SEL_O,
   input  wire logic        CONV_DONE_I,
   input  wire logic [9:0]  CONV_DATA_I
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0]                ctrl0_q;
   logic [7:0]                ctrl0_d;
   logic [7:0]                ctrl1_q;
   logic [1:0]                status_q;
   logic [1:0]                status_d;
   logic [1:0]                mask_q;
   logic [1:0]                intctl_q;
   logic [7:0]                rdata_d;
   logic                      done_s;
   logic                      done_prev_q;
   logic [9:0]                data_s;
   adc_ctrl_pkg::conv_cfg_t   cfg;
   adc_ctrl_pkg::conv_state_t conv_q;
   adc_ctrl_pkg::conv_state_t conv_d;
   adc_ctrl_pkg::wake_state_t wake_q;
   adc_ctrl_pkg::wake_state_t wake_d;
   adc_ctrl_pkg::result_t     result;
   logic                      wr_ctrl0;
   logic                      wr_ctrl1;
   logic                      wr_status;
   logic                      wr_mask;
   logic                      wr_intctl;
   logic                      go_write;
   logic                      go_accept;
   logic                      go_refuse;
   logic                      done_rise;
   logic                      conv_done;
   logic                      conv_off;
   logic                      run_ok;
   logic                      start;
   logic                      adc_irq;
   logic                      wake_cond;
   logic                      vector_cond;
   logic [1:0]                st_set;
   logic [1:0]                st_clr;

   initial
   begin
      if (RESULT_W != 10) $error("adc_conv_ctrl: only a 10-bit result is served");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the converter side

   sync2 #(
      .W (1)
   ) u_done_sync (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .d_i     (CONV_DONE_I),
      .q_o     (done_s)
   );

   // Data must be stable before done rises; both pass the same two stages
   sync2 #(
      .W (10)
   ) u_data_sync (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .d_i     (CONV_DATA_I),
      .q_o     (data_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register decode

   assign wr_ctrl0  = WR_I && (ADDR_I == `ADC_ADDR_CTRL0);
   assign wr_ctrl1  = WR_I && (ADDR_I == `ADC_ADDR_CTRL1);
   assign wr_status = WR_I && (ADDR_I == `ADC_ADDR_STATUS);
   assign wr_mask   = WR_I && (ADDR_I == `ADC_ADDR_MASK);
   assign wr_intctl = WR_I && (ADDR_I == `ADC_ADDR_INTCTL);

   assign cfg.on      = ctrl0_q[`ADC_ON_BIT];
   assign cfg.chan    = ctrl0_q[`ADC_CHAN_LSB +: 3];
   assign cfg.clksel  = ctrl1_q[`ADC_CLKSEL_LSB +: 3];
   assign cfg.justify = ctrl1_q[`ADC_JUSTIFY_BIT];

   // Go only sticks when the converter is switched on in the same write
   assign go_write  = wr_ctrl0 && WDATA_I[`ADC_GO_BIT];
   assign go_accept = go_write && WDATA_I[`ADC_ON_BIT];              // R11
   assign go_refuse = go_write && !WDATA_I[`ADC_ON_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencing

   assign run_ok    = !ASLEEP_O || (cfg.clksel == `ADC_CLKSEL_RC);    // R8
   assign done_rise = done_s && !done_prev_q;
   assign conv_done = (conv_q == adc_ctrl_pkg::CONV_BUSY) && done_rise && cfg.on;
   assign conv_off  = (conv_q == adc_ctrl_pkg::CONV_BUSY) && !cfg.on;
   assign start     = (conv_q == adc_ctrl_pkg::CONV_IDLE) && ctrl0_q[`ADC_GO_BIT]
                      && cfg.on && run_ok;                            // R11

   always_comb
   begin
      conv_d = conv_q;
      case (conv_q)
         adc_ctrl_pkg::CONV_IDLE:
            if (start)
               conv_d = adc_ctrl_pkg::CONV_BUSY;
         adc_ctrl_pkg::CONV_BUSY:
            if (conv_done || conv_off)
               conv_d = adc_ctrl_pkg::CONV_IDLE;
         default:
            conv_d = adc_ctrl_pkg::CONV_IDLE;
      endcase
   end

   // Writing go as zero never clears go; only completion or switching off does
   always_comb
   begin
      ctrl0_d = ctrl0_q;
      if (wr_ctrl0)
      begin
         ctrl0_d = WDATA_I;
         ctrl0_d[`ADC_GO_BIT] = ctrl0_q[`ADC_GO_BIT] || go_accept;
      end
      if (conv_done || conv_off || (wr_ctrl0 && !WDATA_I[`ADC_ON_BIT]))
         ctrl0_d[`ADC_GO_BIT] = 1'b0;                                  // R12 R15
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         conv_q      <= adc_ctrl_pkg::CONV_IDLE;
         ctrl0_q     <= `ADC_RST_CTRL0;
         done_prev_q <= 1'b0;
      end
      else
      begin
         conv_q      <= conv_d;
         ctrl0_q     <= ctrl0_d;
         done_prev_q <= done_s;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         ctrl1_q <= `ADC_RST_CTRL1;
      else if (wr_ctrl1)
         ctrl1_q <= WDATA_I;
   end

   result_format u_result (
      .clk_i     (CLK_I),
      .rst_n_i   (RST_N_I),
      .load_i    (conv_done),                                         // R15
      .justify_i (cfg.justify),                                       // R9
      .data_i    (data_s),
      .result_o  (result)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status, mask and interrupt controls

   // A set in the clearing cycle wins, so no completion is lost
   assign st_set = {go_refuse, conv_done};                            // R1
   assign st_clr = wr_status ? WDATA_I[1:0] : 2'h0;                   // R2
   assign status_d = (status_q & ~st_clr) | st_set;

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         status_q <= `ADC_RST_STATUS;
         mask_q   <= `ADC_RST_MASK;
         intctl_q <= `ADC_RST_INTCTL;
      end
      else
      begin
         status_q <= status_d;
         if (wr_mask)
            mask_q <= WDATA_I[1:0];
         if (wr_intctl)
            intctl_q <= {WDATA_I[`ADC_GIE_BIT], WDATA_I[`ADC_PERIPHERAL_IRQ_ENABLE_BIT]};
      end
   end

   assign adc_irq = status_q[`ADC_ST_DONE_BIT] && mask_q[`ADC_ST_DONE_BIT]; // R3
   assign IRQ_O   = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Sleep, wake and vectoring

   assign wake_cond   = adc_irq && intctl_q[0];                       // R4 R6
   assign vector_cond = wake_cond && intctl_q[1];                     // R7

   always_comb
   begin
      wake_d = wake_q;
      case (wake_q)
         adc_ctrl_pkg::WK_AWAKE:
            if (SLEEP_REQ_I)
               wake_d = adc_ctrl_pkg::WK_ASLEEP;
         adc_ctrl_pkg::WK_ASLEEP:
            if (wake_cond)
               wake_d = adc_ctrl_pkg::WK_NEXT;                        // R4
         adc_ctrl_pkg::WK_NEXT:
            wake_d = adc_ctrl_pkg::WK_AWAKE;                          // R5
         default:
            wake_d = adc_ctrl_pkg::WK_AWAKE;
      endcase
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         wake_q <= adc_ctrl_pkg::WK_AWAKE;
      else
         wake_q <= wake_d;
   end

   assign ASLEEP_O    = (wake_q == adc_ctrl_pkg::WK_ASLEEP);
   assign WAKE_O      = ASLEEP_O && wake_cond;
   assign EXEC_NEXT_O = (wake_q == adc_ctrl_pkg::WK_NEXT);            // R5
   // Vectoring waits until the instruction after sleep has been issued
   assign VECTOR_O    = (wake_q == adc_ctrl_pkg::WK_AWAKE) && vector_cond; // R6 R7

   ////////////////////////////////////////////////////////////////////////////
   // Converter outputs

   assign CONV_START_O   = start;
   assign CONV_RUN_O     = (conv_q == adc_ctrl_pkg::CONV_BUSY) && cfg.on && run_ok; // R8
   assign CONV_CHANNEL_O = cfg.chan;
   assign CONV_CLK_SEL_O = cfg.clksel;

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   always_comb
   begin
      case (ADDR_I)
         `ADC_ADDR_CTRL0:  rdata_d = ctrl0_q;
         `ADC_ADDR_CTRL1:  rdata_d = ctrl1_q;
         `ADC_ADDR_RES_HI: rdata_d = result.hi;
         `ADC_ADDR_RES_LO: rdata_d = result.lo;
         `ADC_ADDR_STATUS: rdata_d = {6'h00, status_q};
         `ADC_ADDR_MASK:   rdata_d = {6'h00, mask_q};
         `ADC_ADDR_INTCTL: rdata_d = {intctl_q[1], intctl_q[0], 6'h00};
         default:          rdata_d = 8'h00;
      endcase
   end

   // Unmapped reads answer zero; data stands only in the cycle after the read
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         RDATA_O <= 8'h00;
      else if (RD_I)
         RDATA_O <= rdata_d;
      else
         RDATA_O <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   sequence seq_wake_event;
      ASLEEP_O && wake_cond;
   endsequence

   sequence seq_next_then_awake;
      EXEC_NEXT_O && !VECTOR_O ##1 !EXEC_NEXT_O && !ASLEEP_O;
   endsequence

   sequence seq_completion;
      conv_done;
   endsequence

   chk_done_flag_set: assert property (seq_completion |=> status_q[0]) // R1
      else $error("done flag not set after completion");

   chk_flag_held: assert property (status_q[0] && !(wr_status && WDATA_I[0])
                                   |=> status_q[0])                    // R2
      else $error("done flag cleared without software");

   chk_irq_gate: assert property ($rose(status_q[0]) && mask_q[0] |-> IRQ_O
                                  && adc_irq)                          // R3
      else $error("interrupt missing for enabled done flag");

   chk_sleep_wake: assert property (seq_wake_event |=> EXEC_NEXT_O)   // R4
      else $error("no wake on converter interrupt");

   chk_next_first: assert property (seq_wake_event |=> seq_next_then_awake) // R5
      else $error("instruction after sleep not issued first");

   chk_inline_resume: assert property (EXEC_NEXT_O && !intctl_q[1] && !wr_intctl
                                       |=> !VECTOR_O && !ASLEEP_O)     // R6
      else $error("vectored with global enable clear");

   chk_vector_all: assert property (EXEC_NEXT_O && vector_cond
                                    && !(wr_intctl || wr_mask || wr_status)
                                    |=> VECTOR_O)                      // R7
      else $error("no vector with all enables set");

   chk_sleep_hold: assert property (ASLEEP_O && cfg.clksel != `ADC_CLKSEL_RC
                                    |-> !CONV_RUN_O && !CONV_START_O)  // R8
      else $error("converter running asleep without RC clock");

   chk_result_layout: assert property (seq_completion |=> ($past(cfg.justify) ?
                      (result.hi == $past(data_s[9:2])) :
                      (result.lo == $past(data_s[7:0]))))              // R10
      else $error("result layout does not follow select");

   chk_go_start: assert property (ctrl0_q[1] && cfg.on && run_ok
                                  && conv_q == adc_ctrl_pkg::CONV_IDLE
                                  |=> conv_q == adc_ctrl_pkg::CONV_BUSY) // R11
      else $error("go flag did not start conversion");

   chk_same_cycle: assert property (seq_completion |=> !ctrl0_q[1] && status_q[0]
                                    && conv_q == adc_ctrl_pkg::CONV_IDLE) // R15
      else $error("go clear and flag set not in one cycle");

   chk_go_cleared: assert property (seq_completion |=> !ctrl0_q[1]) // R12
      else $error("go flag not cleared on completion");

endmodule

/* logic/adc_ctrl_defs.svh */
// Register offsets, field positions and reset values of the converter control block
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// Register offsets
`define ADC_ADDR_CTRL0      4'h0
`define ADC_ADDR_CTRL1      4'h1
`define ADC_ADDR_RES_HI     4'h2
`define ADC_ADDR_RES_LO     4'h3
`define ADC_ADDR_STATUS     4'h4
`define ADC_ADDR_MASK       4'h5
`define ADC_ADDR_INTCTL     4'h6

// Field positions
`define ADC_ON_BIT          0
`define ADC_GO_BIT          1
`define ADC_CHAN_LSB        2
`define ADC_CLKSEL_LSB      4
`define ADC_JUSTIFY_BIT     7
`define ADC_ST_DONE_BIT     0
`define ADC_ST_REFUSED_BIT  1
`define ADC_PERIPHERAL_IRQ_ENABLE_BIT        6
`define ADC_GIE_BIT         7

// Field codes
`define ADC_CLKSEL_RC       3'h7

// Reset values
`define ADC_RST_CTRL0       8'h00
`define ADC_RST_CTRL1       8'h00
`define ADC_RST_STATUS      2'h0
`define ADC_RST_MASK        2'h0
`define ADC_RST_INTCTL      2'h0

`endif

/* logic/adc_ctrl_pkg.sv */
// Types shared by the converter control block
package adc_ctrl_pkg;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } result_t;

   typedef struct packed {
      logic       on;
      logic [2:0] chan;
      logic [2:0] clksel;
      logic       justify;
   } conv_cfg_t;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_BUSY = 2'b01
   } conv_state_t;

   typedef enum logic [1:0] {
      WK_AWAKE  = 2'b00,
      WK_ASLEEP = 2'b01,
      WK_NEXT   = 2'b10
   } wake_state_t;

endpackage

/* logic/result_format.sv */
// Result byte store with left or right justification
`timescale 1ns/1ps
module result_format (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   // Load
   input  wire logic                     load_i,
   input  wire logic                     justify_i,
   input  wire logic [9:0]               data_i,
   // Result
   output adc_ctrl_pkg::result_t         result_o
);

   adc_ctrl_pkg::result_t left_w;
   adc_ctrl_pkg::result_t right_w;

   assign left_w.hi  = data_i[9:2];             // R14
   assign left_w.lo  = {data_i[1:0], 6'h00};    // R14
   assign right_w.hi = {6'h00, data_i[9:8]};    // R14
   assign right_w.lo = data_i[7:0];             // R14

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         result_o <= '0;
      else if (load_i)
         result_o <= justify_i ? left_w : right_w; // R10
   end

endmodule

/* logic/sync2.sv */
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_q;

   initial
   begin
      if (W < 1) $error("sync2: width must be at least one");
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         meta_q <= '0;
         q_o    <= '0;
      end
      else
      begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule

/* verification/adc_conv_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conv_ctrl_tb;
   typedef struct {
      string      name;
      logic [7:0] value;
   } note_t;
   note_t       notes[$];
   note_t       cur;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rd_d = 1'b0;
   logic        sleep_req = 1'b0;
   logic [7:0]  delay = 8'h08;
   logic [9:0]  value = 10'h000;
   logic [7:0]  rdata;
   logic        asleep, wake, exec_next, vector, irq, start, run, done;
   logic [2:0]  chan, clk_sel;
   logic [9:0]  data;
   logic [31:0] seed = 32'h34;
   int          fail_count = 0;
   int          compares = 0;
   int          cycles = 0;

   always #2 clk = ~clk;

   adc_conv_ctrl adc_conv_ctrl_i (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SLEEP_REQ_I(sleep_req), .ASLEEP_O(asleep),
      .WAKE_O(wake), .EXEC_NEXT_O(exec_next), .VECTOR_O(vector), .IRQ_O(irq),
      .CONV_START_O(start), .CONV_RUN_O(run), .CONV_CHANNEL_O(chan), .CONV_CLK_SEL_O(clk_sel),
      .CONV_DONE_I(done), .CONV_DATA_I(data));

   conv_model conv_model_i (.clk_i(clk), .rst_n_i(rst_n), .start_i(start), .run_i(run),
      .delay_i(delay), .value_i(value), .done_o(done), .data_o(data));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic close_out();
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Expected read data is queued; the watcher below compares it
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string n);
      note_t nt;
      nt.name  = n;
      nt.value = e;
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      notes.push_back(nt);
      @(posedge clk);
      rd   <= 1'b0;
   endtask

   task automatic go_sleep();
      @(posedge clk);
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
   endtask

   // Bounded wait, so a dead block ends as a mismatch
   // Selector instead of a reference: 0 watches done, 1 watches wake
   task automatic wait_high(input bit w, input string n);
      int k;
      k = 0;
      while ((w ? wake : done) !== 1'b1 && k < 300)
      begin
         @(negedge clk);
         k++;
      end
      check(n, {9'h0, (w ? wake : done)}, 10'h001);
   endtask

   task automatic convert(input logic j, input logic [2:0] ch, input logic [7:0] dly);
      logic [7:0] c0;
      logic [9:0] v;
      c0   = {3'h0, ch, 2'h1};
      seed = xs(seed);
      v    = seed[9:0];
      wr_reg(4'h1, {j, 7'h00});
      wr_reg(4'h0, c0);
      @(posedge clk);
      value <= v;
      delay <= dly;
      wr_reg(4'h0, c0 | 8'h02);
      @(negedge clk);
      check("start pulse", {9'h0, start}, 10'h001);
      check("channel", {7'h0, chan}, {7'h0, ch});
      check("clock select", {7'h0, clk_sel}, 10'h000);
      rd_reg(4'h0, c0 | 8'h02, "go while busy");
      wait_high(1'b0, "converter done");
      repeat (5) @(posedge clk);
      rd_reg(4'h0, c0, "go after completion");
      rd_reg(4'h2, j ? v[9:2] : {6'h0, v[9:8]}, "result high");
      rd_reg(4'h3, j ? {v[1:0], 6'h0} : v[7:0], "result low");
      rd_reg(4'h4, 8'h01, "done flag");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
      rd_d <= rd;

   always @(negedge clk)
      if (rd_d && notes.size() > 0)
      begin
         cur = notes.pop_front();
         check(cur.name, {2'h0, rdata}, {2'h0, cur.value});
      end
      else if (rst_n)
         check("idle read data", {2'h0, rdata}, 10'h000);

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 8; a++)
         rd_reg(a[3:0], 8'h00, "reset value");
      wr_reg(4'h9, 8'hff);
      rd_reg(4'h9, 8'h00, "unmapped read");
      for (int k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         convert(k[0], seed[2:0], k < 2 ? 8'h0c : 8'h40);
      end
      @(negedge clk);
      check("irq masked", {9'h0, irq}, 10'h000);
      wr_reg(4'h5, 8'h01);
      @(negedge clk);
      check("irq enabled", {9'h0, irq}, 10'h001);
      wr_reg(4'h4, 8'h01);
      @(negedge clk);
      check("irq cleared", {9'h0, irq}, 10'h000);
      rd_reg(4'h4, 8'h00, "flag cleared");
      wr_reg(4'h0, 8'h02);
      rd_reg(4'h0, 8'h00, "go refused when off");
      rd_reg(4'h4, 8'h02, "refused flag");
      wr_reg(4'h4, 8'h03);
      // Switching off mid conversion aborts it without a flag
      wr_reg(4'h0, 8'h03);
      wr_reg(4'h0, 8'h00);
      rd_reg(4'h0, 8'h00, "go after switch off");
      rd_reg(4'h4, 8'h00, "no flag after switch off");
      for (int g = 0; g < 2; g++)
      begin
         wr_reg(4'h6, {g[0], 7'h40});
         wr_reg(4'h1, 8'h00);
         wr_reg(4'h0, 8'h01);
         delay <= 8'h06;
         go_sleep();
         wr_reg(4'h0, 8'h03);
         repeat (40) @(negedge clk);
         check("asleep", {9'h0, asleep}, 10'h001);
         check("run while asleep", {9'h0, run}, 10'h000);
         check("no flag asleep", {9'h0, irq}, 10'h000);
         wr_reg(4'h1, 8'h70);
         @(negedge clk);
         check("clock select rc", {7'h0, clk_sel}, 10'h007);
         check("start asleep rc", {9'h0, start}, 10'h001);
         @(negedge clk);
         check("run asleep rc", {9'h0, run}, 10'h001);
         wait_high(1'b1, "wake");
         check("asleep at wake", {9'h0, asleep}, 10'h001);
         @(negedge clk);
         check("next instruction", {9'h0, exec_next}, 10'h001);
         check("awake", {9'h0, asleep}, 10'h000);
         @(negedge clk);
         check("vector", {9'h0, vector}, {9'h0, g[0]});
         check("next pulse ends", {9'h0, exec_next}, 10'h000);
         wr_reg(4'h4, 8'h01);
         @(negedge clk);
         check("vector cleared", {9'h0, vector}, 10'h000);
      end
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule

/* verification/conv_model.sv */
// Behavioural sample-and-convert circuit facing the converter control block
`timescale 1ns/1ps
module conv_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control from the block; delay and value from the bench
   input  wire logic       start_i,
   input  wire logic       run_i,
   input  wire logic [7:0] delay_i,
   input  wire logic [9:0] value_i,
   // Result to the block
   output logic            done_o,
   output logic [9:0]      data_o
);
   logic       busy_q;
   logic [7:0] cnt_q;
   logic [2:0] hold_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Data held well past the sync delay, then inverted so stale data never matches
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
         hold_q <= 3'h0;
         done_o <= 1'b0;
         data_o <= 10'h155;
      end
      else if (start_i)
      begin
         busy_q <= 1'b1;
         cnt_q  <= delay_i;
      end
      else if (busy_q && run_i)
      begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h00)
         begin
            busy_q <= 1'b0;
            data_o <= value_i;
            hold_q <= 3'h6;
         end
      end
      else if (hold_q != 3'h0)
      begin
         hold_q <= hold_q - 3'h1;
         done_o <= (hold_q != 3'h1);
         if (hold_q == 3'h1)
            data_o <= ~data_o;
      end
   end
endmodule
